// file: tb/card_sense_block_tb.sv
`timescale 1ns/100ps
module card_sense_block_tb;
  import ccd_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic io_wr = 1'b0, io_rd = 1'b0, rd_q = 1'b0, module_changed_clear = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic [1:0] pin, ce_n, host_ce_n = 2'h3;
  logic host_wr_n = 1'b1;
  logic flag, irq;
  wire ccd_pad_drive_t pad;
  logic [3:0] m = 4'hd;
  logic [11:0] e;
  logic [11:0] exp_q[$];
  logic [31:0] r;
  int n_fail = 0, check_count = 0, cyc = 0;
  // ----
  // harness
  // ----
  card_sense_block #(.SLEEP_PERIOD_CYC(1200)) dut (
    .mclk, .reset_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .module_changed_clear,
    .card_sense_pins_in(pin), .card_sense_pins_out(pad.out), .card_sense_pins_oe(pad.oe),
    .host_ce_n, .host_wr_n, .card_chip_enables_n(ce_n), .module_changed_flag(flag),
    .shared_interrupt_request(irq));
  ccd_card_model card (.mclk, .mode(m), .pad, .pin);
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    rd_q <= io_rd;
    cyc <= cyc + 1;
    if (cyc == 16000) begin
      n_fail++;
      conclude();
    end
  end
  always @(negedge mclk) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      cmp(e, {ce_n, irq, flag, io_rdata});
    end
  end
  task automatic cmp(logic [11:0] x, logic [11:0] y);
    check_count++;
    if (y !== x) begin
      n_fail++;
      $display("CHECK FAILED read result expected %h seen %h", x, y);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [3:0] st(logic [3:0] c);
    return {c[2], c[0], c[2] & ~c[3], c[0] & ~c[1]};
  endfunction
  task idle(int n);
    repeat (n) begin
      @(posedge mclk);
      r = $urandom;
      {host_wr_n, host_ce_n} <= r[2:0];
    end
  endtask
  task wr(logic [7:0] d);
    @(posedge mclk);
    io_addr <= CCD_CTRL_ADDR;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
  endtask
  // reads hold a write cycle on both enables so blocking shows as well
  task chk(logic f, logic [3:0] s, logic [15:0] a = CCD_CTRL_ADDR);
    exp_q.push_back({~s[1:0], f, f, (a == CCD_CTRL_ADDR) ? {s, 4'h0} : 8'h00});
    @(posedge mclk);
    io_addr <= a;
    io_rd <= 1'b1;
    host_ce_n <= 2'h0;
    host_wr_n <= 1'b0;
    @(posedge mclk);
    io_rd <= 1'b0;
  endtask
  initial begin
    r = $urandom(32'h07c3_723b);
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    idle(3);
    chk(1'b0, 4'h0);
    wr(8'h02);
    idle(950);
    chk(1'b1, st(m));
    chk(1'b1, st(m), 16'he305);
    wr(8'h06);
    chk(1'b0, st(m));
    m <= 4'h5;
    idle(1200);
    chk(1'b1, st(m));
    m <= 4'h4;
    idle(1200);
    chk(1'b1, st(m));
    @(posedge mclk);
    module_changed_clear <= 1'b1;
    @(posedge mclk);
    module_changed_clear <= 1'b0;
    chk(1'b0, st(m));
    wr(8'h00);
    m <= 4'hd;
    idle(1300);
    chk(1'b0, st(4'h4));
    wr(8'h03);
    idle(950);
    chk(1'b1, st(m));
    idle(2500);
    conclude();
  end
endmodule

// file: tb/ccd_card_model.sv
`timescale 1ns/100ps
// ----
// card outputs beat the weak pad drive
// ----
module ccd_card_model
  import ccd_pkg::*;
(
  input wire logic mclk,
  input wire logic [3:0] mode,
  input wire ccd_pad_drive_t pad,
  output logic [1:0] pin
);
  logic t_q = 1'b0;
  // an empty undriven socket must not look steady
  always @(posedge mclk) t_q <= ~t_q;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin[i] = mode[2*i] ? mode[2*i+1] : (pad.oe[i] ? pad.out[i] : t_q);
    end
  end
endmodule

// file: tb/ccd_properties.sv
`timescale 1ns/100ps
module ccd_properties
  import ccd_pkg::*;
#(
  parameter int SLEEP_PERIOD_CYC = CCD_SLEEP_PERIOD_CYC
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic module_changed_clear,
  input wire logic [1:0] card_sense_pins_out,
  input wire logic [1:0] card_sense_pins_oe,
  input wire logic [1:0] host_ce_n,
  input wire logic host_wr_n,
  input wire logic [1:0] card_chip_enables_n,
  input wire logic module_changed_flag
);
  // ----
  // mode shadow and properties
  // ----
  localparam int GAP = SLEEP_PERIOD_CYC - 2 * CCD_PHASE_CYC;
  localparam int CONT_GAP = CCD_CONT_PERIOD_CYC - 2 * CCD_PHASE_CYC;
  wire [1:0] oe = card_sense_pins_oe;
  wire [1:0] out = card_sense_pins_out;
  wire flag = module_changed_flag;
  wire hit = io_wr && io_addr == CCD_CTRL_ADDR;
  logic [1:0] mode_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= 2'h0;
    end else if (hit) begin
      mode_q <= io_wdata[1:0];
    end
  end
  logic [3:0] ok_q;
  logic [15:0] gap_q;
  // the design frees its own reset two edges late; checks wait for its first real cycle
  // gap_q counts idle pad cycles, restarted by a drive or by any control write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ok_q <= 4'h0;
      gap_q <= 16'h0000;
    end else begin
      ok_q <= {ok_q[2:0], 1'b1};
      if (oe[0] || hit) begin
        gap_q <= 16'h0000;
      end else if (gap_q != 16'hffff) begin
        gap_q <= gap_q + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!ok_q[3]);
  ce_pass_a: assert property ($past(host_wr_n) |-> card_chip_enables_n == $past(host_ce_n))
    else $error("chip enable not passed");
  drive_low_a: assert property ($rose(oe[0]) |-> oe == 2'h3 && out == 2'h0)
    else $error("pads not driven low first");
  // an aborted cycle may end in the low phase
  drive_end_a: assert property ($rose(oe[0]) |-> ##[1:600] ($fell(oe[0]) &&
    ($past(out) == 2'h3 || !mode_q[1])))
    else $error("drive phase too long");
  idle_float_a: assert property (!mode_q[1] [*3] |-> oe == 2'h0)
    else $error("pads driven while off");
  flag_rise_a: assert property ($rose(flag) |-> $fell(oe[0]))
    else $error("flag set outside update");
  flag_clr_a: assert property ((hit && io_wdata[CCD_CLR_BIT]) || module_changed_clear
    |=> !flag || $fell(oe[0]))
    else $error("flag not cleared");
  cont_gap_a: assert property (mode_q == 2'h3 |-> int'(gap_q) <= CONT_GAP)
    else $error("continuous period late");
  sleep_gap_a: assert property (mode_q == 2'h2 |-> int'(gap_q) <= GAP)
    else $error("enable-only period late");
endmodule
bind card_sense_block ccd_properties #(.SLEEP_PERIOD_CYC(SLEEP_PERIOD_CYC)) props (
  .mclk, .reset_n, .io_addr, .io_wr, .io_wdata, .module_changed_clear, .card_sense_pins_out,
  .card_sense_pins_oe, .host_ce_n, .host_wr_n, .card_chip_enables_n, .module_changed_flag);

// file: verilog/card_sense_block.sv
`timescale 1ns/100ps
// Overview of operation
// - low pin: card writable; high: card protected; floating: no card.
// - each cycle floats the pads, then drives weakly low, then weakly high.
// - run plus enable: repeat every 122us, contending about 30us per period.
// - enable only: refresh every 1ms, contending no more than 30us.
// - writing one to control bit 2 clears the changed flag; bit write-only.
// - bits 4,5 writable and 6,7 inserted, read-only, reset 0; bit 3 unused.
// - unwritable port blocks write cycles on its chip enable.
// - any status change sets the changed flag and the shared interrupt.
// - no new change interrupt until the changed flag is cleared.
// - first enable with a card inserted raises a change interrupt.
// - protected card pad going low on power loss reports a change.
module card_sense_block
  import ccd_pkg::*;
#(
  parameter int SLEEP_PERIOD_CYC = CCD_SLEEP_PERIOD_CYC
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic module_changed_clear,
  input wire logic [1:0] card_sense_pins_in,
  output logic [1:0] card_sense_pins_out,
  output logic [1:0] card_sense_pins_oe,
  input wire logic [1:0] host_ce_n,
  input wire logic host_wr_n,
  output logic [1:0] card_chip_enables_n,
  output logic module_changed_flag,
  output logic shared_interrupt_request
);

  typedef struct packed {
    logic [1:0] sense_meta;
    logic [1:0] sense_sync;
    logic run_continuous_sense;
    logic sense_enable;
    ccd_phase_t phase;
    logic [CCD_CNT_W-1:0] phase_cnt;
    logic [1:0] lo_sample;
    ccd_status_t status;
    logic flag;
    ccd_pad_drive_t pad;
    logic [1:0] ce_n;
    logic [7:0] rdata;
  } ccd_state_t;

  ccd_state_t st_q;
  ccd_state_t st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic tick;
  logic [CCD_CNT_W-1:0] period;
  logic reg_sel;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // returns {inserted, writable}; a pad that follows both weak drives floats
  function automatic logic [1:0] ccd_classify(input logic lo, input logic hi);
    if (!lo && hi) begin
      ccd_classify = 2'b00;
    end else begin
      ccd_classify = {1'b1, ~hi};
    end
  endfunction

  assign reg_sel = (io_addr == CCD_CTRL_ADDR);

  // the sleep period is in cycles to let a simulation shorten it
  assign period = st_q.run_continuous_sense ? CCD_CNT_W'(CCD_CONT_PERIOD_CYC)
                                            : CCD_CNT_W'(SLEEP_PERIOD_CYC);

  ccd_tick_div u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(st_q.sense_enable),
    .period(period),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] cls0;
    logic [1:0] cls1;
    ccd_status_t fresh;
    logic change;
    logic clr;
    cls0 = 2'b00;
    cls1 = 2'b00;
    fresh = st_q.status;
    change = 1'b0;
    clr = 1'b0;
    st_d = st_q;

    // pins are asynchronous to mclk
    st_d.sense_meta = card_sense_pins_in;
    st_d.sense_sync = st_q.sense_meta;

    if (io_wr && reg_sel) begin
      st_d.run_continuous_sense = io_wdata[CCD_RUN_BIT];
      st_d.sense_enable = io_wdata[CCD_EN_BIT];
      clr = io_wdata[CCD_CLR_BIT];
    end

    case (st_q.phase)
      CCD_IDLE: begin
        st_d.phase_cnt = '0;
        if (tick) begin
          st_d.phase = CCD_FLOAT;
        end
      end
      CCD_FLOAT: begin
        st_d.phase_cnt = st_q.phase_cnt + 1'b1;
        if (st_q.phase_cnt == CCD_CNT_W'(CCD_PHASE_CYC - 1)) begin
          st_d.phase_cnt = '0;
          st_d.phase = CCD_DRIVE_LO;
        end
      end
      CCD_DRIVE_LO: begin
        st_d.phase_cnt = st_q.phase_cnt + 1'b1;
        if (st_q.phase_cnt == CCD_CNT_W'(CCD_PHASE_CYC - 1)) begin
          st_d.phase_cnt = '0;
          st_d.lo_sample = st_q.sense_sync;
          st_d.phase = CCD_DRIVE_HI;
        end
      end
      CCD_DRIVE_HI: begin
        st_d.phase_cnt = st_q.phase_cnt + 1'b1;
        if (st_q.phase_cnt == CCD_CNT_W'(CCD_PHASE_CYC - 1)) begin
          st_d.phase_cnt = '0;
          st_d.phase = CCD_IDLE;
          cls0 = ccd_classify(st_q.lo_sample[0], st_q.sense_sync[0]);
          cls1 = ccd_classify(st_q.lo_sample[1], st_q.sense_sync[1]);
          fresh = '{port1_inserted: cls1[1], port0_inserted: cls0[1],
                    port1_writable: cls1[0], port0_writable: cls0[0]};
          change = (fresh != st_q.status);
          st_d.status = fresh;
        end
      end
      default: begin
        st_d.phase = CCD_IDLE;
      end
    endcase

    // a cycle cut short by disabling leaves the old status untouched
    if (!st_q.sense_enable) begin
      st_d.phase = CCD_IDLE;
      st_d.phase_cnt = '0;
      st_d.status = st_q.status;
      change = 1'b0;
    end

    // the flag stays up until cleared; a change in the clear cycle wins and keeps it set
    if (clr || module_changed_clear) begin
      st_d.flag = 1'b0;
    end
    if (change) begin
      st_d.flag = 1'b1;
    end

    // pad drive follows the phase being entered
    case (st_d.phase)
      CCD_DRIVE_LO: begin
        st_d.pad = '{oe: 2'b11, out: 2'b00};
      end
      CCD_DRIVE_HI: begin
        st_d.pad = '{oe: 2'b11, out: 2'b11};
      end
      default: begin
        st_d.pad = '{oe: 2'b00, out: 2'b00};
      end
    endcase

    // write cycles to a protected port never reach the card
    st_d.ce_n[0] = host_ce_n[0] | (~host_wr_n & ~st_q.status.port0_writable);
    st_d.ce_n[1] = host_ce_n[1] | (~host_wr_n & ~st_q.status.port1_writable);

    if (io_rd && reg_sel) begin
      st_d.rdata = {st_q.status, CCD_RD_LOW_NIB};
    end else begin
      st_d.rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.phase <= CCD_IDLE;
      st_q.run_continuous_sense <= CCD_MODE_RST[CCD_RUN_BIT];
      st_q.sense_enable <= CCD_MODE_RST[CCD_EN_BIT];
      st_q.status <= CCD_STATUS_RST;
      st_q.ce_n <= 2'h3;
    end else begin
      st_q <= st_d;
    end
  end

  assign io_rdata = st_q.rdata;
  assign card_sense_pins_out = st_q.pad.out;
  assign card_sense_pins_oe = st_q.pad.oe;
  assign card_chip_enables_n = st_q.ce_n;
  assign module_changed_flag = st_q.flag;
  assign shared_interrupt_request = st_q.flag;

endmodule

// file: verilog/ccd_pkg.sv
package ccd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] CCD_CTRL_ADDR = 16'he304;
  localparam int CCD_RUN_BIT = 0;
  localparam int CCD_EN_BIT = 1;
  localparam int CCD_CLR_BIT = 2;
  localparam int CCD_STAT_LSB = 4;
  localparam int CCD_STAT_MSB = 7;
  localparam logic [3:0] CCD_STATUS_RST = 4'h0;
  localparam logic [1:0] CCD_MODE_RST = 2'h0;
  localparam logic [3:0] CCD_RD_LOW_NIB = 4'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CCD_CLK_PERIOD_NS = 50;
  localparam int CCD_CONT_PERIOD_NS = 122000;
  localparam int CCD_SLEEP_PERIOD_NS = 1000000;
  localparam int CCD_CONTEND_NS = 30000;
  localparam int CCD_CONT_PERIOD_CYC = CCD_CONT_PERIOD_NS / CCD_CLK_PERIOD_NS;
  localparam int CCD_SLEEP_PERIOD_CYC = CCD_SLEEP_PERIOD_NS / CCD_CLK_PERIOD_NS;
  // contention is a longest time, split over the two driven phases: floor
  localparam int CCD_PHASE_CYC = CCD_CONTEND_NS / (2 * CCD_CLK_PERIOD_NS);
  localparam int CCD_CNT_W = 15;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CCD_IDLE, CCD_FLOAT, CCD_DRIVE_LO, CCD_DRIVE_HI} ccd_phase_t;

  typedef struct packed {
    logic port1_inserted;
    logic port0_inserted;
    logic port1_writable;
    logic port0_writable;
  } ccd_status_t;

  typedef struct packed {
    logic [1:0] oe;
    logic [1:0] out;
  } ccd_pad_drive_t;

endpackage

// file: verilog/ccd_tick_div.sv
`timescale 1ns/100ps
module ccd_tick_div
  import ccd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [CCD_CNT_W-1:0] period,
  output logic tick
);

  typedef struct packed {
    logic [CCD_CNT_W-1:0] cnt;
    logic tick;
  } ccd_div_state_t;

  ccd_div_state_t st_q;
  ccd_div_state_t st_d;

  // ----------------------------------------------------------------
  // divider: first tick right after run rises, then one per period
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run) begin
      st_d.cnt = '0;
    end else begin
      st_d.tick = (st_q.cnt == '0);
      if (st_q.cnt >= period - 1'b1) begin
        st_d.cnt = '0;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule
